// file: logic/kpi_pkg.sv
/*
  Shared constants for the keyboard pin interrupt unit: register
  indices, decoder select codes, field positions, reset values, bus answers.
  Assumes a 32-bit AXI4-Lite register bus and eight keyboard pins.
*/
package kpi_pkg;

  // pin count and bus widths
  localparam int          PIN_COUNT  = 8;
  localparam int          ADDR_W     = 16;
  localparam int          DATA_W     = 32;

  // printed register indices; byte address is four times the index
  localparam logic [15:0] IDX_SCR    = 16'h001A;
  localparam logic [15:0] IDX_ENABLE = 16'h001B;
  localparam logic [15:0] IDX_POLAR  = 16'h0448;
  localparam logic [15:0] IDX_BREAK  = 16'h0020;

  // select codes used by the address decoder
  localparam logic [2:0]  SEL_NONE   = 3'h0;
  localparam logic [2:0]  SEL_SCR    = 3'h1;
  localparam logic [2:0]  SEL_ENABLE = 3'h2;
  localparam logic [2:0]  SEL_POLAR  = 3'h3;
  localparam logic [2:0]  SEL_BREAK  = 3'h4;

  // status/control and break register field positions
  localparam int          BIT_TRIG   = 0;
  localparam int          BIT_MASK   = 1;
  localparam int          BIT_ACK    = 2;
  localparam int          BIT_FLAG   = 3;
  localparam int          BIT_BRKCLR = 0;

  // reset values
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic        RST_BIT    = 1'b0;

  // bus answers
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLV   = 2'h2;

endpackage

// file: logic/kpi_keyboard.sv
/*
  Keyboard pin interrupt unit: eight port pins with enable and polarity,
  edge-only or edge-and-level triggering, a latched request with
  pending flag, mask and acknowledge, reached over AXI4-Lite.
  Assumes pins synchronous enough for a two-stage synchroniser, and a
  CPU that pulses VECTOR_FETCH for one cycle when it takes the vector.
*/
`timescale 1ns/1ps

// What this block does
// R1: an edge is deasserted in one sampled cycle then asserted the next
// R2: eight enableable pins on port A share one request and one mask
// R3: edge-only mode ignores an edge while another enabled pin is asserted
// R4: edge-and-level mode holds the request while any enabled pin asserts
// R5: level mode clears only after acknowledge and all pins released
// R6: a vector fetch acknowledges the request
// R7: writing one to the acknowledge bit clears; it reads as zero
// R8: an edge after an acknowledge latches a fresh request
// R9: a latched unmasked request raises the interrupt for vector FFE0/FFE1
// R10: edge-only mode clears at once on acknowledge
// R11: reset clears the request and the sensitivity bit
// R12: pending flag shows the latched request, independent of the mask
// R13: the mask bit suppresses the interrupt; reset clears it
// R14: enable bits admit pins; disabled pins are ignored; reset clears
// R15: an enabled pin is forced to be an input
// R16: polarity one means rising/high, zero falling/low; reset clears
// R17: polarity picks pullup at zero, pulldown at one, for enabled pins
// R18: in break, software acknowledge works only with break clear enable
// R19: active in wait and stop; an unmasked request wakes the part
// R20: software masks, configures, acknowledges, then unmasks
// R21: control bits 0..3 are sensitivity, mask, acknowledge, flag
// R22: sensitivity one gives edge and level, zero edges only
// R23: each pin passes two flip-flops before detection
module kpi_keyboard
  import kpi_pkg::*;
(
  // clock and reset
  input  wire logic                 CLOCK,
  input  wire logic                 RST,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0]    AWADDR,
  input  wire logic                 AWVALID,
  output logic                      AWREADY,
  // axi4-lite write data
  input  wire logic [DATA_W-1:0]    WDATA,
  input  wire logic [3:0]           WSTRB,
  input  wire logic                 WVALID,
  output logic                      WREADY,
  // axi4-lite write response
  output logic [1:0]                BRESP,
  output logic                      BVALID,
  input  wire logic                 BREADY,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0]    ARADDR,
  input  wire logic                 ARVALID,
  output logic                      ARREADY,
  // axi4-lite read data
  output logic [DATA_W-1:0]         RDATA,
  output logic [1:0]                RRESP,
  output logic                      RVALID,
  input  wire logic                 RREADY,
  // keyboard pins and port control
  input  wire logic [PIN_COUNT-1:0] PORT_A_PINS,
  output logic [PIN_COUNT-1:0]      FORCE_INPUT,
  output logic [PIN_COUNT-1:0]      PULLUP_EN,
  output logic [PIN_COUNT-1:0]      PULLDOWN_EN,
  // cpu side
  input  wire logic                 VECTOR_FETCH,
  input  wire logic                 BREAK_STATE,
  output logic                      KBD_IRQ,
  output logic                      WAKEUP
);

  // address decode shared by the write and read paths
  function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
    logic [2:0] s;
    s = SEL_NONE;
    if (a == {IDX_SCR[13:0], 2'b00}) begin
      s = SEL_SCR;
    end else if (a == {IDX_ENABLE[13:0], 2'b00}) begin
      s = SEL_ENABLE;
    end else if (a == {IDX_POLAR[13:0], 2'b00}) begin
      s = SEL_POLAR;
    end else if (a == {IDX_BREAK[13:0], 2'b00}) begin
      s = SEL_BREAK;
    end
    return s;
  endfunction

  // software visible state
  logic [PIN_COUNT-1:0] pin_enable_bits;
  logic [PIN_COUNT-1:0] pin_polarity_bits;
  logic                 trigger_sensitivity;
  logic                 request_mask_bit;
  logic                 break_clear_enable;

  // detection state
  logic [PIN_COUNT-1:0] sync_a;
  logic [PIN_COUNT-1:0] sync_b;
  logic [PIN_COUNT-1:0] pin_act;
  logic                 any_act;
  logic                 act_prev;
  logic                 req_latch;
  logic                 edge_seen;
  logic                 ack_strobe;
  logic                 sw_ack;
  logic                 ack_any;
  logic                 pending_flag;
  logic                 next_latch;

  // write channel holding state
  logic                 aw_got;
  logic                 w_got;
  logic [ADDR_W-1:0]    aw_addr;
  logic [7:0]           w_byte;
  logic                 w_lane;

  // write channel wires
  logic                 aw_take;
  logic                 w_take;
  logic                 wr_go;
  logic [ADDR_W-1:0]    wr_addr;
  logic [7:0]           wr_byte;
  logic                 wr_lane;
  logic [2:0]           wr_sel;
  logic                 wr_en;

  // read channel wires
  logic                 ar_take;
  logic [2:0]           rd_sel;
  logic [7:0]           rd_byte;

  // two-stage pin synchroniser
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      sync_a <= RST_BYTE;
      sync_b <= RST_BYTE;
    end else begin
      sync_a <= PORT_A_PINS; // R23
      sync_b <= sync_a;      // R23
    end
  end

  // per-pin asserted level after polarity, gated by enable
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
      assign pin_act[gi] = pin_enable_bits[gi] // R14
                         & ~(sync_b[gi] ^ pin_polarity_bits[gi]); // R16
      assign PULLUP_EN[gi]   = pin_enable_bits[gi] & ~pin_polarity_bits[gi]; // R17
      assign PULLDOWN_EN[gi] = pin_enable_bits[gi] & pin_polarity_bits[gi];  // R17
    end
  endgenerate

  // enabled pins force the port to input
  assign FORCE_INPUT = pin_enable_bits; // R15

  // combined keyboard level; an edge only when none was asserted before
  assign any_act   = |pin_act;             // R2
  assign edge_seen = any_act & ~act_prev;  // R1 R3 R8

  // acknowledge sources; a break without clear enable blocks software
  assign sw_ack  = ack_strobe & (~BREAK_STATE | break_clear_enable); // R18
  assign ack_any = VECTOR_FETCH | sw_ack;  // R6 R7

  // set wins over clear so an edge in the ack cycle is kept
  assign next_latch = edge_seen | (req_latch & ~ack_any); // R8 R10

  // level term keeps the request while a pin stays asserted
  assign pending_flag = req_latch
                      | (trigger_sensitivity & any_act); // R4 R5 R22

  // interrupt and wakeup: same unmasked request, any power mode
  assign KBD_IRQ = pending_flag & ~request_mask_bit; // R9 R13
  assign WAKEUP  = pending_flag & ~request_mask_bit; // R19

  // request latch and previous sample
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      req_latch <= RST_BIT; // R11
      act_prev  <= RST_BIT;
    end else begin
      req_latch <= next_latch;
      act_prev  <= any_act; // R1
    end
  end

  // write channel handshake
  assign AWREADY = ~aw_got & ~BVALID;
  assign WREADY  = ~w_got & ~BVALID;
  assign aw_take = AWVALID & AWREADY;
  assign w_take  = WVALID & WREADY;
  assign wr_go   = (aw_got | aw_take) & (w_got | w_take);

  // pick held or arriving address and data
  assign wr_addr = aw_got ? aw_addr : AWADDR;
  assign wr_byte = w_got ? w_byte : WDATA[7:0];
  assign wr_lane = w_got ? w_lane : WSTRB[0];
  assign wr_sel  = reg_sel(wr_addr);
  assign wr_en   = wr_go & wr_lane;

  // acknowledge is a one-cycle strobe from a status/control write
  assign ack_strobe = wr_en & (wr_sel == SEL_SCR)
                    & wr_byte[BIT_ACK]; // R7

  // hold whichever half of a write arrives first
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      aw_got  <= 1'b0;
      w_got   <= 1'b0;
      aw_addr <= '0;
      w_byte  <= RST_BYTE;
      w_lane  <= 1'b0;
    end else begin
      aw_got <= ~wr_go & (aw_got | aw_take);
      w_got  <= ~wr_go & (w_got | w_take);
      if (aw_take) begin
        aw_addr <= AWADDR;
      end
      if (w_take) begin
        w_byte <= WDATA[7:0];
        w_lane <= WSTRB[0];
      end
    end
  end

  // write response
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      BVALID <= 1'b0;
      BRESP  <= RESP_OKAY;
    end else if (wr_go) begin
      BVALID <= 1'b1;
      BRESP  <= (wr_sel == SEL_NONE) ? RESP_SLV : RESP_OKAY;
    end else if (BREADY) begin
      BVALID <= 1'b0;
    end
  end

  // control registers
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      trigger_sensitivity <= RST_BIT;  // R11
      request_mask_bit    <= RST_BIT;  // R13
      pin_enable_bits     <= RST_BYTE; // R14
      pin_polarity_bits   <= RST_BYTE; // R16
      break_clear_enable  <= RST_BIT;
    end else if (wr_en) begin
      case (wr_sel)
        SEL_SCR: begin
          trigger_sensitivity <= wr_byte[BIT_TRIG]; // R21 R22
          request_mask_bit    <= wr_byte[BIT_MASK]; // R21
        end
        SEL_ENABLE: begin
          pin_enable_bits <= wr_byte;
        end
        SEL_POLAR: begin
          pin_polarity_bits <= wr_byte;
        end
        SEL_BREAK: begin
          break_clear_enable <= wr_byte[BIT_BRKCLR];
        end
        default: begin
        end
      endcase
    end
  end

  // read mux: ack and upper nibble read as zero
  assign ar_take = ARVALID & ARREADY;
  assign ARREADY = ~RVALID;
  assign rd_sel  = reg_sel(ARADDR);
  assign rd_byte = (rd_sel == SEL_SCR)    ? {4'h0, pending_flag, 1'b0,
                                             request_mask_bit,
                                             trigger_sensitivity} // R12 R21
                 : (rd_sel == SEL_ENABLE) ? pin_enable_bits
                 : (rd_sel == SEL_POLAR)  ? pin_polarity_bits
                 : (rd_sel == SEL_BREAK)  ? {7'h00, break_clear_enable}
                 : RST_BYTE;

  // read data channel
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      RVALID <= 1'b0;
      RDATA  <= '0;
      RRESP  <= RESP_OKAY;
    end else if (ar_take) begin
      RVALID <= 1'b1;
      RDATA  <= {24'h000000, rd_byte};
      RRESP  <= (rd_sel == SEL_NONE) ? RESP_SLV : RESP_OKAY;
    end else if (RREADY) begin
      RVALID <= 1'b0;
    end
  end

  // edge on a quiet bus latches the flag next cycle
  chk_edge_latches: assert property ( // R1
    @(posedge CLOCK) disable iff (RST)
    (any_act && !act_prev) |=> pending_flag)
    else $error("edge did not latch a request");

  // edge-only: no new latch while an enabled pin is held
  chk_held_blocks: assert property ( // R3
    @(posedge CLOCK) disable iff (RST)
    (!trigger_sensitivity && act_prev && !req_latch) |=> !req_latch)
    else $error("request latched while a pin was held");

  // level mode keeps the request up
  chk_level_hold: assert property ( // R4
    @(posedge CLOCK) disable iff (RST)
    (trigger_sensitivity && any_act) |-> pending_flag)
    else $error("level request dropped");

  // ack while held leaves request, release then clears
  chk_level_clear: assert property ( // R5
    @(posedge CLOCK) disable iff (RST)
    (trigger_sensitivity && ack_any && act_prev && any_act)
      |=> (!req_latch && (pending_flag == (trigger_sensitivity && any_act))))
    else $error("level clear sequence wrong");

  // edge-only ack clears at once; the same write may switch to level mode
  chk_edge_ack: assert property ( // R10
    @(posedge CLOCK) disable iff (RST)
    (!trigger_sensitivity && ack_any && !edge_seen)
      |=> (!req_latch && (pending_flag == (trigger_sensitivity && any_act))))
    else $error("edge-only ack did not clear");

  // mask gates the interrupt, flag does not care
  chk_mask_gate: assert property ( // R9
    @(posedge CLOCK) disable iff (RST)
    KBD_IRQ == (pending_flag && !request_mask_bit))
    else $error("interrupt does not follow flag and mask");

  // ack bit and top nibble read zero
  chk_scr_read: assert property ( // R21
    @(posedge CLOCK) disable iff (RST)
    (ar_take && rd_sel == SEL_SCR)
      |=> (RDATA[BIT_ACK] == 1'b0 && RDATA[7:4] == 4'h0
           && RDATA[BIT_FLAG] == $past(pending_flag)))
    else $error("status/control read wrong");

  // protected break ignores a software ack
  chk_break_guard: assert property ( // R18
    @(posedge CLOCK) disable iff (RST)
    (BREAK_STATE && !break_clear_enable && !VECTOR_FETCH && req_latch)
      |=> req_latch)
    else $error("ack took effect during protected break");

  // no pin counts while every pin is disabled
  chk_pin_ignore: assert property ( // R14
    @(posedge CLOCK) disable iff (RST)
    (pin_enable_bits == 8'h00) |-> !any_act)
    else $error("disabled pin counted");

  // second stage only ever takes the first stage
  chk_sync_chain: assert property ( // R23
    @(posedge CLOCK) disable iff (RST)
    sync_b == $past(sync_a))
    else $error("pin synchroniser skipped a stage");

  // software ack outside break drops the latch
  chk_ack_clear: assert property ( // R7
    @(posedge CLOCK) disable iff (RST)
    (ack_strobe && !BREAK_STATE && !edge_seen) |=> !req_latch)
    else $error("software ack did not clear the latch");

  // open break lets a software ack through
  chk_break_open: assert property ( // R18
    @(posedge CLOCK) disable iff (RST)
    (BREAK_STATE && break_clear_enable && ack_strobe && !edge_seen) |=> !req_latch)
    else $error("ack blocked with break clear enabled");

  // exactly one pull device on each enabled pin, none on disabled pins
  chk_pull_pick: assert property ( // R17
    @(posedge CLOCK) disable iff (RST)
    !(|(PULLUP_EN & PULLDOWN_EN)) && ((PULLUP_EN | PULLDOWN_EN) == pin_enable_bits))
    else $error("pull device selection wrong");

endmodule

// file: sim/kpi_switch_model.sv
/*
  Switch model on the keyboard pins: a closed switch drives its level,
  an open one falls to the enabled pull device or floats.
  Assumes the pull enables come from the unit under test.
*/
`timescale 1ns/1ps

module kpi_switch_model (
  // clock
  input  wire logic       clk,
  // switch control from the bench
  input  wire logic [7:0] closed,
  input  wire logic [7:0] drive_lvl,
  // pull devices from the unit
  input  wire logic [7:0] pullup_en,
  input  wire logic [7:0] pulldown_en,
  // pin levels
  output logic [7:0]      pins
);
  logic [7:0] float_lvl;

  // an undriven, unpulled pin changes every cycle
  always_ff @(posedge clk) begin
    float_lvl <= (float_lvl === 8'h55) ? 8'hAA : 8'h55;
  end

  // closed switch wins, then pullup, pulldown gives low, else floating
  assign pins = (closed & drive_lvl) | (~closed & pullup_en)
              | (~closed & ~pullup_en & ~pulldown_en & float_lvl);
endmodule

// file: sim/tb_kpi_keyboard.sv
/*
  Self-checking bench for the keyboard pin interrupt unit: register
  access over AXI4-Lite, switch stimulus through the pin model.
  Assumes the unit answers each bus request within a few cycles.
*/
`timescale 1ns/1ps

module tb_kpi_keyboard import kpi_pkg::*; ;
  localparam logic [15:0] A_SCR = IDX_SCR << 2;
  localparam logic [15:0] A_EN  = IDX_ENABLE << 2;
  localparam logic [15:0] A_POL = IDX_POLAR << 2;
  localparam logic [15:0] A_BRK = IDX_BREAK << 2;
  localparam logic [7:0]  POL   = 8'h0F;
  logic              clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic              awready, wready, bvalid, arready, rvalid;
  logic              vec_fetch, brk_state, irq, wake;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata, rd;
  logic [1:0]        bresp, rresp, resp;
  logic [7:0]        pins, force_in, pu_en, pd_en, closed;
  int                error_cnt, checked;

  // clock
  always #5 clk = ~clk;

  kpi_keyboard kpi_keyboard_inst (
    .CLOCK(clk), .RST(rst), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .PORT_A_PINS(pins), .FORCE_INPUT(force_in), .PULLUP_EN(pu_en), .PULLDOWN_EN(pd_en),
    .VECTOR_FETCH(vec_fetch), .BREAK_STATE(brk_state), .KBD_IRQ(irq), .WAKEUP(wake)
  );

  kpi_switch_model kpi_switch_model_inst (
    .clk(clk), .closed(closed), .drive_lvl(POL),
    .pullup_en(pu_en), .pulldown_en(pd_en), .pins(pins)
  );

  // verdict and end of run
  task automatic final_report();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // a used-up wait ends the run
  task automatic guard(input int n);
    if (n >= 50) begin
      error_cnt++;
      $display("FAIL bus wait expected answer seen none");
      final_report();
    end
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
  endtask

  // write: address and data together, each released when taken
  task automatic bus_write(input logic [15:0] a, input logic [7:0] d);
    logic aw = 1'b0;
    logic w = 1'b0;
    int   n = 0;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw && w) && n < 50) begin
      #1;
      aw = aw | (awvalid & (awready === 1'b1));
      w  = w | (wvalid & (wready === 1'b1));
      @(posedge clk);
      n++;
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    #1;
    while (bvalid !== 1'b1 && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    resp = bresp;
    @(posedge clk);
    bready <= 1'b0;
    guard(n);
  endtask

  task automatic bus_read(input logic [15:0] a);
    int n = 0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    #1;
    while (arready !== 1'b1 && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    arvalid <= 1'b0;
    #1;
    while (rvalid !== 1'b1 && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    rd   = rdata;
    resp = rresp;
    @(posedge clk);
    rready <= 1'b0;
    guard(n);
  endtask

  task automatic reg_chk(input string what, input logic [15:0] a, input logic [31:0] exp);
    bus_read(a);
    cmp(what, exp, rd);
  endtask

  // set switches, then let synchroniser and latch settle
  task automatic press(input logic [7:0] c);
    @(posedge clk);
    closed <= c;
    repeat (6) @(posedge clk);
    #1;
  endtask

  task automatic fetch();
    @(posedge clk);
    vec_fetch <= 1'b1;
    @(posedge clk);
    vec_fetch <= 1'b0;
  endtask

  // main sequence
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, vec_fetch, brk_state} = '0;
    {awaddr, araddr, wdata, closed} = '0;
    error_cnt = 0;
    checked = 0;
    do_reset();
    reg_chk("scr reset", A_SCR, 32'h0);
    reg_chk("enable reset", A_EN, 32'h0);
    reg_chk("polarity reset", A_POL, 32'h0);
    bus_read(16'h0004);
    cmp("unmapped resp", RESP_SLV, resp);
    cmp("unmapped data", 32'h0, rd);
    bus_write(16'h0004, 8'hFF);
    cmp("unmapped bresp", RESP_SLV, resp);
    // masked set-up, flush, unmask
    bus_write(A_SCR, 8'h02);
    bus_write(A_EN, 8'hFF);
    bus_write(A_POL, POL);
    cmp("force input", 8'hFF, force_in);
    cmp("pullup", 8'hF0, pu_en);
    cmp("pulldown", POL, pd_en);
    cmp("write bresp", RESP_OKAY, resp);
    press(8'h00);
    bus_write(A_SCR, 8'h06);
    bus_write(A_SCR, 8'h00);
    reg_chk("scr flushed", A_SCR, 32'h0);
    // rising edge on pin 0
    press(8'h01);
    cmp("irq", 1'b1, irq);
    cmp("wakeup", 1'b1, wake);
    press(8'h00);
    reg_chk("scr latched", A_SCR, 32'h08);
    bus_write(A_SCR, 8'h02);
    cmp("irq masked", 1'b0, irq);
    cmp("wakeup masked", 1'b0, wake);
    reg_chk("scr masked", A_SCR, 32'h0A);
    bus_write(A_SCR, 8'h04);
    reg_chk("scr acked", A_SCR, 32'h0);
    // falling pin 4, fetch while held, pin 1 edge blocked
    press(8'h10);
    fetch();
    reg_chk("fetch clears", A_SCR, 32'h0);
    press(8'h12);
    reg_chk("edge blocked", A_SCR, 32'h0);
    press(8'h00);
    press(8'h02);
    reg_chk("fresh edge", A_SCR, 32'h08);
    press(8'h00);
    bus_write(A_SCR, 8'h04);
    // level mode: both orders of ack and release
    bus_write(A_SCR, 8'h01);
    press(8'h04);
    bus_write(A_SCR, 8'h05);
    reg_chk("level held", A_SCR, 32'h09);
    press(8'h00);
    reg_chk("level released", A_SCR, 32'h01);
    press(8'h04);
    press(8'h00);
    reg_chk("level latched", A_SCR, 32'h09);
    bus_write(A_SCR, 8'h05);
    reg_chk("level acked", A_SCR, 32'h01);
    bus_write(A_SCR, 8'h00);
    // disabled pin ignored
    bus_write(A_EN, 8'hFE);
    press(8'h01);
    reg_chk("disabled pin", A_SCR, 32'h0);
    press(8'h00);
    bus_write(A_EN, 8'hFF);
    press(8'h00);
    bus_write(A_SCR, 8'h04);
    // break state protection
    press(8'h02);
    @(posedge clk);
    brk_state <= 1'b1;
    bus_write(A_SCR, 8'h04);
    reg_chk("break protect", A_SCR, 32'h08);
    bus_write(A_BRK, 8'h01);
    reg_chk("break ctl", A_BRK, 32'h01);
    bus_write(A_SCR, 8'h04);
    brk_state <= 1'b0;
    reg_chk("break cleared", A_SCR, 32'h0);
    // reset in level mode with a pin held
    bus_write(A_SCR, 8'h01);
    press(8'h04);
    do_reset();
    #1;
    cmp("irq after reset", 1'b0, irq);
    reg_chk("scr after reset", A_SCR, 32'h0);
    final_report();
  end
endmodule
